// File: inc/fma_pkg.sv
// Shared types, constants and helpers of the fused multiply-add unit.
package fma_pkg;

  localparam int VEC_W   = 256;
  localparam int HALF_W  = 128;
  localparam int D_W     = 64;
  localparam int S_W     = 32;
  localparam int D_EW    = 11;
  localparam int D_MW    = 52;
  localparam int S_EW    = 8;
  localparam int S_MW    = 23;
  localparam int D_LANES = VEC_W / D_W;
  localparam int S_LANES = VEC_W / S_W;
  localparam int DEST_W  = 5;

  localparam logic [D_W-1:0] D_DNAN = 64'hfff8000000000000;
  localparam logic [D_W-1:0] D_INF  = 64'h7ff0000000000000;
  localparam logic [D_W-1:0] D_QBIT = 64'h0008000000000000;
  localparam logic [D_W-1:0] D_ONE  = 64'h3ff0000000000000;
  localparam logic [D_W-1:0] D_TWO  = 64'h4000000000000000;
  localparam logic [D_W-1:0] D_NEG0 = 64'h8000000000000000;
  localparam logic [S_W-1:0] S_ONE  = 32'h3f800000;
  localparam logic [S_W-1:0] S_TWO  = 32'h40000000;

  typedef enum logic [1:0] {
    FM_ADD  = 2'b00,
    FM_SUB  = 2'b01,
    FM_NADD = 2'b10,
    FM_NSUB = 2'b11
  } form_e;

  typedef enum logic [1:0] {
    RM_NEAR = 2'b00,
    RM_DOWN = 2'b01,
    RM_UP   = 2'b10,
    RM_ZERO = 2'b11
  } rm_e;

  typedef struct packed {
    logic              valid;
    form_e             form;
    rm_e               rm;
    logic              dbl;
    logic              scalar;
    logic              wide;
    logic [DEST_W-1:0] dest;
    logic [VEC_W-1:0]  src1;
    logic [VEC_W-1:0]  src2;
    logic [VEC_W-1:0]  src3;
  } req_s;

  typedef struct packed {
    logic              valid;
    logic [DEST_W-1:0] dest;
    logic [VEC_W-1:0]  data;
    logic              invalid_op_flag;
  } rsp_s;

  function automatic logic d_nan(input logic [D_W-1:0] v);
    return (&v[62:52]) && (|v[51:0]);
  endfunction

  function automatic logic d_snan(input logic [D_W-1:0] v);
    return d_nan(v) && !v[51];
  endfunction

  function automatic logic d_inf(input logic [D_W-1:0] v);
    return (&v[62:52]) && !(|v[51:0]);
  endfunction

  function automatic logic d_zero(input logic [D_W-1:0] v);
    return !(|v[62:0]);
  endfunction

  function automatic logic s_snan(input logic [S_W-1:0] v);
    return (&v[30:23]) && (|v[21:0]) && !v[22];
  endfunction

endpackage

// File: logic/fma_lane.sv
// One element lane: exact product, exact sum, one rounding, special cases.
module fma_lane #(
  parameter int EW = 11,
  parameter int MW = 52
) (
  // Operands: multiplicand, multiplier, addend.
  input  wire logic [EW+MW:0] a,
  input  wire logic [EW+MW:0] b,
  input  wire logic [EW+MW:0] c,
  // Operation form and rounding.
  input  wire logic           neg_prod,
  input  wire logic           neg_add,
  input  wire fma_pkg::rm_e   rm,
  // Result.
  output logic [EW+MW:0]      r,
  output logic                invalid
);

  localparam int W    = EW + MW + 1;
  localparam int BIAS = (1 << (EW - 1)) - 1;
  localparam int EMAX = (1 << EW) - 1;
  localparam int G    = 3;
  localparam int CAP  = 2 * MW + G + 4;
  localparam int FW   = 3 * MW + G + 6;
  localparam logic [W-1:0] DNAN = {1'b1, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};

  if (EW < 2 || MW < 3 || EW > 15) $error("fma_lane: unsupported widths");

  function automatic logic is_nan(input logic [W-1:0] v);
    return (&v[W-2:MW]) && (|v[MW-1:0]);
  endfunction

  function automatic logic is_inf(input logic [W-1:0] v);
    return (&v[W-2:MW]) && !(|v[MW-1:0]);
  endfunction

  function automatic logic is_zero(input logic [W-1:0] v);
    return !(|v[W-2:0]);
  endfunction

  function automatic logic [W-1:0] quiet(input logic [W-1:0] v);
    return {v[W-1:MW], 1'b1, v[MW-2:0]};
  endfunction

  function automatic int bexp(input logic [W-1:0] v);
    return (v[W-2:MW] == '0) ? 1 : int'(v[W-2:MW]);
  endfunction

  always_comb begin
    logic [2*MW+1:0] p;
    logic [MW:0]     ma;
    logic [MW:0]     mb;
    logic [MW:0]     mc;
    logic [FW-1:0]   pf;
    logic [FW-1:0]   cf;
    logic [FW-1:0]   rr;
    logic [FW-1:0]   q;
    logic [MW+1:0]   qm;
    logic            sp;
    logic            sc;
    logic            sgn;
    logic            rb;
    logic            st;
    logic            inc;
    int              sh;
    int              wb;
    int              ld;
    int              lp;
    int              ex;
    rr  = '0;
    q   = '0;
    sgn = 1'b0;
    rb  = 1'b0;
    st  = 1'b0;
    inc = 1'b0;
    ma = {|a[W-2:MW], a[MW-1:0]};
    mb = {|b[W-2:MW], b[MW-1:0]};
    mc = {|c[W-2:MW], c[MW-1:0]};
    // The product is kept at full width, so nothing is lost before the sum.
    p  = ma * mb;
    sp = a[W-1] ^ b[W-1] ^ neg_prod;
    sc = c[W-1] ^ neg_add;
    sh = bexp(c) - bexp(a) - bexp(b) + BIAS + MW + G;
    wb = bexp(a) + bexp(b) - 2 * BIAS - 2 * MW - G;
    pf = FW'(p) << G;
    cf = '0;
    if (sh > CAP) begin
      // Product lies wholly below the addend's guard bits: keep it as sticky.
      wb = wb + sh - CAP;
      pf = FW'(|p);
      cf = FW'(mc) << CAP;
    end else if (sh >= 0) begin
      cf = FW'(mc) << sh;
    end else begin
      cf = FW'(mc) >> (-sh);
      cf[0] = cf[0] | ((cf << (-sh)) != FW'(mc));
    end
    if (sp == sc) begin
      rr  = pf + cf;
      sgn = sp;
    end else if (pf >= cf) begin
      rr  = pf - cf;
      sgn = sp;
    end else begin
      rr  = cf - pf;
      sgn = sc;
    end
    ld = 0;
    for (int i = 0; i < FW; i++) begin
      if (rr[i]) begin
        ld = i;
      end
    end
    lp = ld - MW;
    if (lp < 1 - BIAS - MW - wb) begin
      lp = 1 - BIAS - MW - wb;
    end
    if (lp > FW) begin
      q  = '0;
      rb = 1'b0;
      st = |rr;
    end else if (lp <= 0) begin
      q  = rr << (-lp);
      rb = 1'b0;
      st = 1'b0;
    end else begin
      q  = rr >> lp;
      rb = rr[lp-1];
      st = (rr << (FW - lp + 1)) != '0;
    end
    // Single rounding step of the exact sum.
    case (rm)
      fma_pkg::RM_NEAR: inc = rb & (st | q[0]);
      fma_pkg::RM_DOWN: inc = sgn & (rb | st);
      fma_pkg::RM_UP:   inc = !sgn & (rb | st);
      default:          inc = 1'b0;
    endcase
    qm = q[MW+1:0] + (MW+2)'(inc);
    ex = lp + wb + MW + BIAS;
    if (qm[MW+1]) begin
      qm = qm >> 1;
      ex = ex + 1;
    end
    invalid = 1'b0;
    if (rr == '0) begin
      // Exact zero: like signs keep the sign, cancellation follows rounding.
      sgn = (sp == sc) ? sp : (rm == fma_pkg::RM_DOWN);
      r   = {sgn, {(W-1){1'b0}}};
    end else if (ex >= EMAX) begin
      if (rm == fma_pkg::RM_NEAR || (rm == fma_pkg::RM_DOWN && sgn) ||
          (rm == fma_pkg::RM_UP && !sgn)) begin
        r = {sgn, {EW{1'b1}}, {MW{1'b0}}};
      end else begin
        r = {sgn, EW'(EMAX - 1), {MW{1'b1}}};
      end
    end else begin
      r = {sgn, (qm[MW] ? EW'(ex) : EW'(0)), qm[MW-1:0]};
    end
    if (is_nan(a) || is_nan(b) || is_nan(c)) begin
      r = is_nan(a) ? quiet(a) : is_nan(b) ? quiet(b) : quiet(c);
      invalid = (is_nan(a) && !a[MW-1]) || (is_nan(b) && !b[MW-1]) ||
                (is_nan(c) && !c[MW-1]);
    end else if ((is_inf(a) && is_zero(b)) || (is_zero(a) && is_inf(b))) begin
      r       = DNAN;
      invalid = 1'b1;
    end else if (is_inf(a) || is_inf(b)) begin
      if (is_inf(c) && sp != sc) begin
        r       = DNAN;
        invalid = 1'b1;
      end else begin
        r = {sp, {EW{1'b1}}, {MW{1'b0}}};
      end
    end else if (is_inf(c)) begin
      r = {sc, {EW{1'b1}}, {MW{1'b0}}};
    end
  end

endmodule

// File: logic/fused_multiply_add_unit.sv
// Vector fused multiply-add unit with one registered result stage.
// What this block does
// - 128/256-bit vectors, up to eight single or four double lanes
// - Three sources; result goes to first source register
// - Scalar: low lane, keep low 128, zero upper
// - Four forms: +-product plus/minus addend
// - Exact product, exact sum, one rounding
// - First NaN of x,y,z; SNaN signals invalid
// - Quiet NaN forwarded; signalling NaN quietened first
// - Default NaN: sign 1, significand top 1
// - Invalid operation returns default NaN, sets flag
// - Infinite product plus infinity: agree or invalid
// - Infinite product with finite addend gives infinity
// - Exact zero sign follows operands and rounding
module fused_multiply_add_unit (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          srst,
  // Issue side.
  input  wire fma_pkg::req_s req,
  // Write-back side.
  output fma_pkg::rsp_s      rsp
);

  ////////////////////////////////////////////////////////////////////////////

  localparam int DL = fma_pkg::D_LANES;
  localparam int SL = fma_pkg::S_LANES;
  localparam int DW = fma_pkg::D_W;
  localparam int SW = fma_pkg::S_W;

  fma_pkg::rsp_s st;
  fma_pkg::rsp_s next_st;
  logic [DW-1:0] dres [DL];
  logic          dinv [DL];
  logic [SW-1:0] sres [SL];
  logic          sinv [SL];

  function automatic int active(input logic scalar, input logic wide,
                                input int per256);
    return scalar ? 1 : (wide ? per256 : per256 / 2);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  for (genvar i = 0; i < DL; i++) begin : g_dbl
    fma_lane #(
      .EW(fma_pkg::D_EW),
      .MW(fma_pkg::D_MW)
    ) u_lane (
      .a       (req.src1[i*DW +: DW]),
      .b       (req.src2[i*DW +: DW]),
      .c       (req.src3[i*DW +: DW]),
      .neg_prod(req.form[1]),
      .neg_add (req.form[0]),
      .rm      (req.rm),
      .r       (dres[i]),
      .invalid (dinv[i])
    );
  end

  for (genvar i = 0; i < SL; i++) begin : g_sgl
    fma_lane #(
      .EW(fma_pkg::S_EW),
      .MW(fma_pkg::S_MW)
    ) u_lane (
      .a       (req.src1[i*SW +: SW]),
      .b       (req.src2[i*SW +: SW]),
      .c       (req.src3[i*SW +: SW]),
      .neg_prod(req.form[1]),
      .neg_add (req.form[0]),
      .rm      (req.rm),
      .r       (sres[i]),
      .invalid (sinv[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_st       = st;
    next_st.valid = req.valid;
    if (req.valid) begin
      next_st.dest = req.dest;
      next_st.data = '0;
      next_st.data[fma_pkg::HALF_W-1:0] =
        req.src1[fma_pkg::HALF_W-1:0];
      next_st.invalid_op_flag = 1'b0;
      if (req.dbl) begin
        for (int i = 0; i < DL; i++) begin
          if (i < active(req.scalar, req.wide, DL)) begin
            next_st.data[i*DW +: DW] = dres[i];
            next_st.invalid_op_flag |= dinv[i];
          end
        end
      end else begin
        for (int i = 0; i < SL; i++) begin
          if (i < active(req.scalar, req.wide, SL)) begin
            next_st.data[i*SW +: SW] = sres[i];
            next_st.invalid_op_flag |= sinv[i];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rsp = st;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_sd;
    req.valid && req.dbl && req.scalar;
  endsequence

  sequence s_ones;
    req.src1[63:0] == fma_pkg::D_ONE && req.src2[63:0] == fma_pkg::D_ONE &&
    req.src3[63:0] == fma_pkg::D_ONE;
  endsequence

  property p_dest;
    req.valid |=> rsp.valid && rsp.dest == $past(req.dest);
  endproperty
  a_dest: assert property (p_dest) else $error("dest not returned");

  property p_upper;
    req.valid && (req.scalar || !req.wide) |=> rsp.data[255:128] == '0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper not zero");

  property p_keep;
    s_sd |=> rsp.data[127:64] == $past(req.src1[127:64]);
  endproperty
  a_keep: assert property (p_keep) else $error("lane not kept");

  property p_fma;
    s_sd and s_ones and req.form == fma_pkg::FM_ADD
      |=> rsp.data[63:0] == fma_pkg::D_TWO;
  endproperty
  a_fma: assert property (p_fma) else $error("1*1+1 wrong");

  property p_cancel;
    s_sd and s_ones and req.form == fma_pkg::FM_NADD
      and req.rm == fma_pkg::RM_NEAR |=> rsp.data[63:0] == '0;
  endproperty
  a_cancel: assert property (p_cancel) else $error("zero sign");

  property p_nan;
    s_sd and fma_pkg::d_nan(req.src1[63:0]) |=> rsp.data[63:0] ==
      ($past(req.src1[63:0]) | fma_pkg::D_QBIT);
  endproperty
  a_nan: assert property (p_nan) else $error("nan not first");

  property p_snan;
    s_sd and (fma_pkg::d_snan(req.src2[63:0]) ||
              fma_pkg::d_snan(req.src3[63:0])) |=> rsp.invalid_op_flag;
  endproperty
  a_snan: assert property (p_snan) else $error("snan no flag");

  property p_dnan;
    s_sd and fma_pkg::d_inf(req.src1[63:0]) and
      fma_pkg::d_zero(req.src2[63:0]) and !fma_pkg::d_nan(req.src3[63:0])
      |=> rsp.data[63:0] == fma_pkg::D_DNAN && rsp.invalid_op_flag;
  endproperty
  a_dnan: assert property (p_dnan) else $error("inf*0");

  property p_conflict;
    s_sd and fma_pkg::d_inf(req.src1[63:0]) and
      fma_pkg::d_inf(req.src2[63:0]) and fma_pkg::d_inf(req.src3[63:0]) and
      (req.src1[63] ^ req.src2[63] ^ req.form[1]) != (req.src3[63] ^
      req.form[0]) |=> rsp.data[63:0] == fma_pkg::D_DNAN &&
      rsp.invalid_op_flag;
  endproperty
  a_conflict: assert property (p_conflict) else $error("inf-inf");

  property p_infprod;
    s_sd and fma_pkg::d_inf(req.src1[63:0]) and
      !fma_pkg::d_zero(req.src2[63:0]) and !fma_pkg::d_nan(req.src2[63:0])
      and !fma_pkg::d_inf(req.src3[63:0]) and
      !fma_pkg::d_nan(req.src3[63:0]) |=> !rsp.invalid_op_flag &&
      rsp.data[63:0] == ({$past(req.src1[63] ^ req.src2[63] ^
      req.form[1]), 63'h0} | fma_pkg::D_INF);
  endproperty
  a_infprod: assert property (p_infprod) else $error("inf prod");

  property p_lane7;
    req.valid && !req.dbl && req.wide && !req.scalar &&
      fma_pkg::s_snan(req.src3[255:224]) |=> rsp.invalid_op_flag;
  endproperty
  a_lane7: assert property (p_lane7) else $error("lane or");

endmodule

// File: sim/issue_regfile_model.sv
// Register file of the issue side that takes the unit's write-backs.
module issue_regfile_model (
  // Clock.
  input  wire logic                        clk,
  // Write-back from the unit.
  input  wire fma_pkg::rsp_s               rsp,
  // Read port for the bench.
  input  wire logic [fma_pkg::DEST_W-1:0]  rd_idx,
  output logic      [fma_pkg::VEC_W-1:0]   rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [fma_pkg::VEC_W-1:0] regs [2**fma_pkg::DEST_W];

  always_ff @(posedge clk) begin
    if (rsp.valid) begin
      regs[rsp.dest] <= rsp.data;
    end
  end

  assign rd_data = regs[rd_idx];
endmodule

// File: sim/test_fused_multiply_add_unit.sv
// Self-checking bench of the fused multiply-add unit.
module test_fused_multiply_add_unit;
  timeunit 1ns;
  timeprecision 1ps;

`define CHECK(got, exp, what) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("mismatch at %0t ns: %s", $time, what); \
  end \
end

  localparam logic [63:0] D3  = 64'h4008000000000000;
  localparam logic [63:0] DM1 = 64'hbff0000000000000;
  localparam logic [63:0] DM3 = 64'hc008000000000000;
  localparam logic [63:0] DNI = 64'hfff0000000000000;
  localparam logic [63:0] DSN = 64'h7ff0000000000007;
  localparam logic [63:0] DQS = 64'h7ff8000000000007;
  localparam logic [63:0] DQN = 64'h7ff8000000000005;
  localparam logic [31:0] S3  = 32'h40400000;
  localparam logic [63:0] DA  = 64'h3ff0000002000000;
  localparam logic [63:0] DR  = 64'h3ff0000004000000;

  logic                  clk;
  logic                  srst;
  fma_pkg::req_s         req;
  fma_pkg::rsp_s         rsp;
  logic [4:0]            rd_idx;
  logic [255:0]          rd_data;
  int                    mismatches;
  int                    compares;
  int                    cycles;

  fused_multiply_add_unit u_fused_multiply_add_unit (
    .clk  (clk),
    .srst (srst),
    .req  (req),
    .rsp  (rsp)
  );

  issue_regfile_model u_issue_regfile_model (
    .clk     (clk),
    .rsp     (rsp),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode is {dbl, scalar, wide}.
  function automatic fma_pkg::req_s mk(input fma_pkg::form_e f,
      input fma_pkg::rm_e m, input logic [2:0] md, input logic [4:0] d,
      input logic [255:0] a, input logic [255:0] b, input logic [255:0] c);
    fma_pkg::req_s r;
    r = '{valid: 1'b1, form: f, rm: m, dbl: md[2], scalar: md[1],
          wide: md[0], dest: d, src1: a, src2: b, src3: c};
    return r;
  endfunction

  task automatic issue(input fma_pkg::req_s r);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    `CHECK(rsp.valid, 1'b1, "no response one cycle after request")
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_forms();
    logic [63:0] exp [4] = '{D3, fma_pkg::D_ONE, DM1, DM3};
    for (int i = 0; i < 4; i++) begin
      issue(mk(fma_pkg::form_e'(i[1:0]), fma_pkg::RM_NEAR, 3'b101, 5'h01,
               {4{fma_pkg::D_ONE}}, {4{fma_pkg::D_TWO}}, {4{fma_pkg::D_ONE}}));
      `CHECK(rsp.data, {4{exp[i]}}, "form result")
      `CHECK(rsp.invalid_op_flag, 1'b0, "flag on plain op")
    end
    // The product must not be rounded before the addend cancels it.
    issue(mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b101, 5'h02,
             {4{DA}}, {4{DA}}, {4{64'hbff0000004000000}}));
    `CHECK(rsp.data, {4{64'h3c90000000000000}}, "single rounding")
    done("forms");
  endtask

  task automatic t_single();
    logic [255:0] b;
    b = {32'h7f800001, {7{fma_pkg::S_TWO}}};
    issue(mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b001, 5'h03,
             {8{fma_pkg::S_ONE}}, {8{fma_pkg::S_TWO}}, {8{fma_pkg::S_ONE}}));
    `CHECK(rsp.data, {8{S3}}, "eight single lanes")
    issue(mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b000, 5'h04,
             {8{fma_pkg::S_ONE}}, b, {8{fma_pkg::S_ONE}}));
    `CHECK(rsp.data, {128'h0, {4{S3}}}, "128-bit single lanes")
    `CHECK(rsp.invalid_op_flag, 1'b0, "flag from idle lane")
    issue(mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b001, 5'h04,
             {8{fma_pkg::S_ONE}}, {8{fma_pkg::S_TWO}},
             {32'h7f800001, {7{fma_pkg::S_ONE}}}));
    `CHECK(rsp.data, {32'h7fc00001, {7{S3}}}, "top single lane nan")
    `CHECK(rsp.invalid_op_flag, 1'b1, "top single lane flag")
    done("single");
  endtask

  task automatic t_scalar();
    issue(mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b110, 5'h05,
             {{3{64'h123456789abcdef0}}, fma_pkg::D_ONE},
             {fma_pkg::D_TWO, fma_pkg::D_TWO, DSN, fma_pkg::D_TWO},
             {4{fma_pkg::D_ONE}}));
    `CHECK(rsp.data, {128'h0, 64'h123456789abcdef0, D3}, "scalar")
    `CHECK(rsp.invalid_op_flag, 1'b0, "scalar flag from idle lane")
    done("scalar");
  endtask

  task automatic t_special();
    logic [63:0] one;
    logic [63:0] inf;
    one = fma_pkg::D_ONE;
    inf = fma_pkg::D_INF;
    issue(mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b110, 5'h0a,
             {4{one}}, {4{one}}, {4{one}}));
    `CHECK(rsp.data, {128'h0, one, fma_pkg::D_TWO}, "scalar sum")
    issue(mk(fma_pkg::FM_NADD, fma_pkg::RM_NEAR, 3'b110, 5'h0a,
             {4{one}}, {4{one}}, {4{one}}));
    `CHECK(rsp.data, {128'h0, one, 64'h0}, "scalar cancel")
    issue(mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b110, 5'h0a,
             {4{DSN}}, {4{one}}, {4{DSN}}));
    `CHECK(rsp.data, {128'h0, DSN, DQS}, "scalar snan")
    `CHECK(rsp.invalid_op_flag, 1'b1, "scalar snan flag")
    issue(mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b110, 5'h0a,
             {4{inf}}, {4{64'h0}}, {4{one}}));
    `CHECK(rsp.data, {128'h0, inf, fma_pkg::D_DNAN}, "inf by zero")
    `CHECK(rsp.invalid_op_flag, 1'b1, "inf by zero flag")
    issue(mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b110, 5'h0a,
             {4{inf}}, {4{inf}}, {4{DNI}}));
    `CHECK(rsp.data, {128'h0, inf, fma_pkg::D_DNAN}, "inf less inf")
    `CHECK(rsp.invalid_op_flag, 1'b1, "inf less inf flag")
    issue(mk(fma_pkg::FM_NADD, fma_pkg::RM_NEAR, 3'b110, 5'h0a,
             {4{inf}}, {4{DM1}}, {4{one}}));
    `CHECK(rsp.data, {128'h0, inf, inf}, "scalar inf product")
    `CHECK(rsp.invalid_op_flag, 1'b0, "inf product flag")
    for (int i = 0; i < 4; i++) begin
      issue(mk(fma_pkg::FM_ADD, fma_pkg::rm_e'(i[1:0]), 3'b110, 5'h0b,
               {4{DA}}, {4{DA}}, {4{64'h0}}));
      `CHECK(rsp.data[63:0], DR + 64'(i == 2), "directed rounding")
    end
    done("special");
  endtask

  task automatic t_nan();
    issue(mk(fma_pkg::FM_SUB, fma_pkg::RM_NEAR, 3'b101, 5'h06,
             {fma_pkg::D_ONE, fma_pkg::D_ONE, fma_pkg::D_ONE, DQN},
             {DQN, fma_pkg::D_ONE, DSN, DSN},
             {fma_pkg::D_ONE, DSN, DQN, fma_pkg::D_ONE}));
    `CHECK(rsp.data, {DQN, DQS, DQS, DQN}, "nan priority")
    `CHECK(rsp.invalid_op_flag, 1'b1, "signalling nan flag")
    issue(mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b101, 5'h07,
             {4{DQN}}, {4{fma_pkg::D_ONE}}, {4{fma_pkg::D_ONE}}));
    `CHECK(rsp.data, {4{DQN}}, "quiet nan forwarded")
    `CHECK(rsp.invalid_op_flag, 1'b0, "quiet nan flag")
    done("nan");
  endtask

  task automatic t_invalid();
    issue(mk(fma_pkg::FM_NADD, fma_pkg::RM_NEAR, 3'b101, 5'h08,
             {4{fma_pkg::D_INF}},
             {DM1, {2{fma_pkg::D_ONE}}, 64'h0},
             {fma_pkg::D_ONE, fma_pkg::D_INF, DNI, fma_pkg::D_ONE}));
    `CHECK(rsp.data[63:0], fma_pkg::D_DNAN, "inf times zero")
    `CHECK(rsp.data[127:64], DNI, "like infinities")
    `CHECK(rsp.data[191:128], fma_pkg::D_DNAN, "opposite inf")
    `CHECK(rsp.data[255:192], fma_pkg::D_INF, "inf product sign")
    `CHECK(rsp.invalid_op_flag, 1'b1, "invalid flag")
    done("invalid");
  endtask

  task automatic t_zero();
    fma_pkg::rm_e m;
    logic [63:0]  z;
    for (int i = 0; i < 4; i++) begin
      m = fma_pkg::rm_e'(i[1:0]);
      z = (m == fma_pkg::RM_DOWN) ? fma_pkg::D_NEG0 : 64'h0;
      issue(mk(fma_pkg::FM_ADD, m, 3'b101, 5'h09,
               {64'h0, fma_pkg::D_ONE, fma_pkg::D_NEG0, 64'h0},
               {4{fma_pkg::D_ONE}},
               {64'h0, DM1, fma_pkg::D_NEG0, fma_pkg::D_NEG0}));
      `CHECK(rsp.data, {64'h0, z, fma_pkg::D_NEG0, z}, "zero sign")
    end
    done("zero");
  endtask

  task automatic t_b2b();
    @(posedge clk);
    req <= mk(fma_pkg::FM_ADD, fma_pkg::RM_NEAR, 3'b101, 5'h03,
              {4{fma_pkg::D_ONE}}, {4{fma_pkg::D_TWO}}, {4{fma_pkg::D_ONE}});
    @(posedge clk);
    req <= mk(fma_pkg::FM_SUB, fma_pkg::RM_NEAR, 3'b101, 5'h1c,
              {4{fma_pkg::D_ONE}}, {4{fma_pkg::D_TWO}}, {4{fma_pkg::D_ONE}});
    #1;
    `CHECK(rsp.dest, 5'h03, "first destination")
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    `CHECK(rsp.valid, 1'b1, "second response")
    `CHECK(rsp.dest, 5'h1c, "second destination")
    rd_idx = 5'h03;
    #1;
    `CHECK(rd_data, {4{D3}}, "first write-back")
    @(posedge clk);
    #1;
    `CHECK(rsp.valid, 1'b0, "response pulse length")
    rd_idx = 5'h1c;
    #1;
    `CHECK(rd_data, {4{fma_pkg::D_ONE}}, "second write-back")
    done("back_to_back");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    req = '0;
    rd_idx = '0;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHECK(rsp, '0, "response after reset")
    done("reset");
    t_forms();
    t_single();
    t_scalar();
    t_special();
    t_nan();
    t_invalid();
    t_zero();
    t_b2b();
    complete_run();
  end
endmodule
